// file: common/flash_id_cfg.svh
// constants for the identification-read and suspend command decoder
// What this block does
// - quad ID read 94h takes zero address, returns maker then device code on four lines
// - quad ID read with address one returns device code first
// - identifier bits leave on serial clock falling edges, most significant first
// - ident read 9Fh returns maker code, memory type, capacity: 24 bits
// - ident read while program or erase runs is not decoded, cycle unaffected
// - chip select high ends ident output at any time; device goes to standby
// - suspend 75h interrupts only a running page program or sector/block erase
// - suspend taken only when both suspend flags clear and busy flag set
// - accepted suspend sets its flag at once, clears busy within suspend latency
// - program suspend rejects status writes, security erase/program, erases, page programs
// - erase suspend rejects status writes, security erase and all erases
// - either suspend accepts status reads and extended-address read and write
// - either suspend accepts every array read variant
// - reset-enable and reset accepted at any time
// - erase suspend accepts page program and quad page program, both address forms
// - erase suspend accepts write enable
// - resume 7Ah accepted while suspended
// - power loss while suspended clears the suspended state
// - resume taken when a suspend flag set and busy clear; busy back within 200ns
`ifndef FLASH_ID_CFG_SVH
`define FLASH_ID_CFG_SVH

`define OP_QIO_ID     8'h94
`define OP_IDENT      8'h9f
`define OP_PAUSE      8'h75
`define OP_CONTINUE   8'h7a
`define OP_WREN       8'h06
`define OP_RST_EN     8'h66
`define OP_RST        8'h99

`define QIO_ADDR_CLKS 5'h06
`define QIO_DUMMY_CLKS 5'h06
`define IDENT_BITS    5'h18

`define CLK_NS        8
`define TSUS_NS       5000
`define TSUS_CYC      (`TSUS_NS / `CLK_NS)
`define TRES_NS       200
`define TRES_CYC      (`TRES_NS / `CLK_NS)

`endif

// file: common/flash_id_pkg.sv
// types shared by the identification and suspend decoder
package flash_id_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_CMD, PH_ADDR, PH_DUMMY, PH_OUT, PH_ONE, PH_SKIP} phase_t;
  typedef enum logic [1:0] {PEND_NONE, PEND_PAUSE, PEND_CONT} pend_t;
endpackage

// file: rtl/flash_id_suspend.sv
// serial flash ID reads, program/erase suspend and resume, suspend-time command filter
`timescale 1ns/100ps
`include "flash_id_cfg.svh"

module flash_id_suspend
  import flash_id_pkg::*;
#(
  parameter logic [7:0] MFR_CODE  = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_CODE  = 8'h3c, // arbitrary value
  parameter logic [7:0] MEM_TYPE  = 8'h40, // arbitrary value
  parameter logic [7:0] MEM_SIZE  = 8'h19  // arbitrary value
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_io,
  input  wire logic       i_power_good,
  input  wire logic       i_op_start,
  input  wire logic       i_op_is_erase,
  input  wire logic       i_op_done,
  output logic      [3:0] o_io,
  output logic      [3:0] o_io_oe_n,
  output logic            o_wip,
  output logic            o_prog_susp,
  output logic            o_erase_susp,
  output logic            o_engine_hold,
  output logic            o_cmd_valid,
  output logic      [7:0] o_cmd_opcode
);

  // assertion windows: the latency count plus slack for the edge detectors
  localparam int TSUS_MAX = `TSUS_CYC + 2;
  localparam int TRES_MAX = `TRES_CYC + 2;

  // ---------------------------------------------------------------
  // opcode filter
  // ---------------------------------------------------------------

  // true when an opcode may pass on to the rest of the device
  function automatic logic permitted(input logic [7:0] op, input logic psus, input logic esus);
    logic always_ok;
    logic erase_ok;
    always_ok = 1'b0;
    erase_ok  = 1'b0;
    case (op)
      8'h05, 8'h35, 8'h15, 8'hc8, 8'hc5: always_ok = 1'b1;
      8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc: always_ok = 1'b1;
      8'h3b, 8'h3c, 8'heb, 8'hec, 8'h6b, 8'h6c: always_ok = 1'b1;
      `OP_RST_EN, `OP_RST: always_ok = 1'b1;
      8'h02, 8'h12, 8'h32, 8'h34, `OP_WREN: erase_ok = 1'b1;
      default: always_ok = 1'b0;
    endcase
    if (!psus && !esus) begin
      permitted = 1'b1;
    end else if (esus) begin
      permitted = always_ok | erase_ok;
    end else begin
      permitted = always_ok;
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------

  logic [1:0] sclk_sy_r;
  logic [1:0] cs_sy_r;
  logic [1:0] pg_sy_r;
  logic [3:0] io_m_r;
  logic [3:0] io_s_r;
  logic       sclk_d_r;
  logic       cs_d_r;

  // two flops on the serial clock, chip select, power-good and io inputs, then one more on clock and select for edge finding
  always_ff @(posedge i_ref_clk) begin
    sclk_sy_r <= {sclk_sy_r[0], i_sclk};
    cs_sy_r   <= {cs_sy_r[0], i_cs_n};
    pg_sy_r   <= {pg_sy_r[0], i_power_good};
    io_m_r    <= i_io;
    io_s_r    <= io_m_r;
    sclk_d_r  <= sclk_sy_r[1];
    cs_d_r    <= cs_sy_r[1];
  end

  // edges are found one flop behind the synchronisers; a high chip select masks
  // every serial clock edge, so a deselect with the clock still high ends cleanly
  wire cs_hi    = cs_sy_r[1];
  wire cs_rise  = cs_sy_r[1] & ~cs_d_r;
  wire sck_rise = ~cs_hi & sclk_sy_r[1] & ~sclk_d_r;
  wire sck_fall = ~cs_hi & ~sclk_sy_r[1] & sclk_d_r;
  wire pwr_lost = ~pg_sy_r[1];

  // ---------------------------------------------------------------
  // serial frame state
  // ---------------------------------------------------------------

  phase_t      phase_r;
  phase_t      phase_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic [7:0]  op_r;
  logic [23:0] addr_r;
  logic [23:0] sh_r;
  logic        quad_r;
  logic [3:0]  io_r;
  logic [3:0]  oe_n_r;

  logic        wip_r;
  logic        psus_r;
  logic        esus_r;
  logic        hold_r;
  pend_t       pend_r;
  logic [11:0] dly_r;
  logic        cmd_valid_r;
  logic [7:0]  cmd_op_r;

  // opcode decode at the eighth rising edge; one-byte commands act only at deselect
  wire [7:0] op_full   = {op_r[6:0], io_s_r[0]};
  wire       op_last   = sck_rise & (phase_r == PH_CMD) & (cnt_r == 5'h07);
  wire       busy_run  = wip_r & ~psus_r & ~esus_r;
  wire       id_cmd    = (op_full == `OP_IDENT) | (op_full == `OP_QIO_ID);
  wire       id_go     = op_last & id_cmd & ~busy_run;
  wire       fwd_ok    = op_last & ~id_cmd & (op_full != `OP_PAUSE) & (op_full != `OP_CONTINUE)
                         & permitted(op_full, psus_r, esus_r);
  wire       one_byte  = cs_rise & (phase_r == PH_ONE);
  wire       pause_cmd = one_byte & (op_r == `OP_PAUSE);
  wire       cont_cmd  = one_byte & (op_r == `OP_CONTINUE);
  wire       pause_go  = pause_cmd & wip_r & ~psus_r & ~esus_r & (pend_r == PEND_NONE) & ~pwr_lost;
  wire       cont_go   = cont_cmd & ~wip_r & (psus_r | esus_r) & (pend_r == PEND_NONE) & ~pwr_lost;
  wire       addr_end  = sck_rise & (phase_r == PH_ADDR) & (cnt_r == `QIO_ADDR_CLKS - 5'h01);
  wire       dummy_end = sck_rise & (phase_r == PH_DUMMY) & (cnt_r == `QIO_DUMMY_CLKS - 5'h01);
  wire       dev_first = ({addr_r[19:0], io_s_r} == 24'h000001);

  // next frame phase and bit count
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    if (cs_hi) begin
      phase_nxt = PH_IDLE;
      cnt_nxt   = 5'h00;
    end else if (phase_r == PH_IDLE) begin
      phase_nxt = PH_CMD;
      cnt_nxt   = 5'h00;
    end else if (sck_rise) begin
      cnt_nxt = cnt_r + 5'h01;
      case (phase_r)
        PH_CMD: begin
          if (cnt_r == 5'h07) begin
            cnt_nxt = 5'h00;
            if (op_full == `OP_QIO_ID && !busy_run) begin
              phase_nxt = PH_ADDR;
            end else if (op_full == `OP_IDENT && !busy_run) begin
              phase_nxt = PH_OUT;
            end else if (op_full == `OP_PAUSE || op_full == `OP_CONTINUE) begin
              phase_nxt = PH_ONE;
            end else begin
              phase_nxt = PH_SKIP;
            end
          end
        end
        PH_ADDR: begin
          if (addr_end) begin
            phase_nxt = PH_DUMMY;
            cnt_nxt   = 5'h00;
          end
        end
        PH_DUMMY: begin
          if (dummy_end) begin
            phase_nxt = PH_OUT;
          end
        end
        PH_ONE:  phase_nxt = PH_SKIP; // extra clocks cancel the one-byte command
        PH_OUT:  cnt_nxt = 5'h00;
        PH_SKIP: cnt_nxt = 5'h00;
        default: phase_nxt = PH_SKIP;
      endcase
    end
  end

  // frame registers and identifier shifting
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      phase_r <= PH_IDLE;
      cnt_r   <= 5'h00;
      op_r    <= 8'h00;
      addr_r  <= 24'h000000;
      sh_r    <= 24'h000000;
      quad_r  <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r   <= cnt_nxt;
      if (sck_rise && phase_r == PH_CMD) begin
        op_r <= op_full;
      end
      if (sck_rise && phase_r == PH_ADDR) begin
        addr_r <= {addr_r[19:0], io_s_r};
      end
      if (id_go && op_full == `OP_IDENT) begin
        sh_r   <= {MFR_CODE, MEM_TYPE, MEM_SIZE};
        quad_r <= 1'b0;
      end else if (addr_end) begin
        sh_r   <= dev_first ? {8'h00, DEV_CODE, MFR_CODE} : {8'h00, MFR_CODE, DEV_CODE};
        quad_r <= 1'b1;
      end else if (sck_fall && phase_r == PH_OUT) begin
        sh_r <= quad_r ? {8'h00, sh_r[11:0], sh_r[15:12]} : {sh_r[22:0], sh_r[23]};
      end
    end
  end

  // output pins change only on falling serial clock, released when deselected
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      io_r   <= 4'h0;
      oe_n_r <= 4'hf;
    end else if (cs_hi || phase_r != PH_OUT) begin
      oe_n_r <= 4'hf;
    end else if (sck_fall) begin
      io_r   <= quad_r ? sh_r[15:12] : {2'b00, sh_r[23], 1'b0};
      oe_n_r <= quad_r ? 4'h0 : 4'hd;
    end
  end

  // ---------------------------------------------------------------
  // busy and suspend flags
  // ---------------------------------------------------------------

  // a pending suspend or resume latency has run out
  wire dly_done = (pend_r != PEND_NONE) & (dly_r == 12'h000);

  // suspend flags change at once and busy follows after the latency count;
  // an engine start in the same cycle as a busy clear wins
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || pwr_lost) begin
      wip_r  <= 1'b0;
      psus_r <= 1'b0;
      esus_r <= 1'b0;
      hold_r <= 1'b0;
      pend_r <= PEND_NONE;
      dly_r  <= 12'h000;
    end else begin
      if (pause_go) begin
        psus_r <= ~i_op_is_erase;
        esus_r <= i_op_is_erase;
        hold_r <= 1'b1;
        pend_r <= PEND_PAUSE;
        dly_r  <= 12'(`TSUS_CYC - 1);
      end else if (cont_go) begin
        psus_r <= 1'b0;
        esus_r <= 1'b0;
        hold_r <= 1'b0;
        pend_r <= PEND_CONT;
        dly_r  <= 12'(`TRES_CYC - 1);
      end else if (dly_done) begin
        pend_r <= PEND_NONE;
      end else if (pend_r != PEND_NONE) begin
        dly_r <= dly_r - 12'h001;
      end
      if (i_op_start || (dly_done && pend_r == PEND_CONT)) begin
        wip_r <= 1'b1;
      end else if (dly_done && pend_r == PEND_PAUSE) begin
        wip_r <= 1'b0;
      end else if (i_op_done && !hold_r) begin
        wip_r <= 1'b0;
      end
    end
  end

  // permitted opcodes forwarded as a one-cycle strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cmd_valid_r <= 1'b0;
      cmd_op_r    <= 8'h00;
    end else begin
      cmd_valid_r <= fwd_ok;
      if (fwd_ok) begin
        cmd_op_r <= op_full;
      end
    end
  end

  assign o_io          = io_r;
  assign o_io_oe_n     = oe_n_r;
  assign o_wip         = wip_r;
  assign o_prog_susp   = psus_r;
  assign o_erase_susp  = esus_r;
  assign o_engine_hold = hold_r;
  assign o_cmd_valid   = cmd_valid_r;
  assign o_cmd_opcode  = cmd_op_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  // remembers whether the frame stood in its output phase one clock ago
  logic out_seen_r;
  always_ff @(posedge i_ref_clk) begin
    out_seen_r <= (phase_r == PH_OUT);
  end

  // output lines stay released while deselected
  deselect_release_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    cs_hi ##1 cs_hi |-> oe_n_r == 4'hf) else $error("pins driven while deselected");

  // accepted suspend: flag and hold at once, busy gone within the suspend latency
  pause_flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    pause_go && !pwr_lost |=> (psus_r ^ esus_r) && hold_r) else $error("suspend flag not set");
  pause_busy_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    pause_go |-> ##[1:TSUS_MAX] !wip_r) else $error("busy not cleared in suspend latency");

  // accepted resume: flags drop at once, busy back within its latency
  cont_busy_set_a: assert property (@(posedge i_ref_clk) disable iff (i_reset || pwr_lost)
    cont_go |=> !psus_r && !esus_r ##[0:TRES_MAX] wip_r) else $error("resume timing wrong");

  // a refused suspend or resume leaves both suspend flags where they were
  pause_ignored_a: assert property (@(posedge i_ref_clk) disable iff (i_reset || pwr_lost)
    pause_cmd && (!wip_r || psus_r || esus_r) |=> $stable(psus_r) && $stable(esus_r)) else $error("bad suspend taken");
  resume_ignored_a: assert property (@(posedge i_ref_clk) disable iff (i_reset || pwr_lost)
    cont_cmd && (wip_r || !(psus_r || esus_r)) |=> $stable(psus_r) && $stable(esus_r) && $stable(hold_r))
    else $error("bad resume taken");

  // forbidden opcodes never leave the filter while suspended
  prog_susp_filter_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_cmd_valid && $past(psus_r) |-> !(o_cmd_opcode inside {8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20,
      8'h52, 8'hd8, 8'hc7, 8'h60, 8'h02, 8'h32, 8'h06})) else $error("opcode passed in program suspend");
  erase_susp_filter_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    o_cmd_valid && $past(esus_r) |-> !(o_cmd_opcode inside {8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52,
      8'hd8, 8'hc7, 8'h60})) else $error("opcode passed in erase suspend");

  // allowed opcodes always leave the filter while suspended, unchanged
  susp_accept_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    op_last && (psus_r || esus_r) && (op_full inside {8'h05, 8'h35, 8'h15, 8'hc8, 8'hc5, 8'h03, 8'h13,
      8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h3b, 8'h3c, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h66, 8'h99})
    |=> o_cmd_valid && o_cmd_opcode == $past(op_full)) else $error("allowed opcode dropped in suspend");
  erase_susp_accept_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    op_last && esus_r && (op_full inside {8'h02, 8'h12, 8'h32, 8'h34, 8'h06})
    |=> o_cmd_valid && o_cmd_opcode == $past(op_full)) else $error("program opcode dropped in erase suspend");

  // identification refused while a cycle runs; other opcodes still pass on
  ident_busy_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    op_last && busy_run && id_cmd |=> phase_r != PH_OUT && !o_cmd_valid) else $error("command decoded while busy");

  // power loss wipes busy and suspend state
  power_loss_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    pwr_lost |=> !psus_r && !esus_r && !wip_r) else $error("suspend kept over power loss");

  // identifier bits move only on a falling serial clock during output
  fall_edge_out_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    $changed(io_r) |-> $past(sck_fall) && out_seen_r) else $error("data changed off falling edge");

endmodule

// file: tb/flash_host_model.sv
// host-side serial flash controller model: frames, opcodes, quad address, read-back
`timescale 1ns/100ps

module flash_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic [3:0] i_dev_io,
  input  wire logic [3:0] i_dev_oe_n,
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic      [3:0] o_io
);
  logic [3:0] din;

  // idle bus: deselected, serial clock parked low
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io   = 4'hf;
  end

  // one serial clock of 64 ns: new data while low, sample late in the high half
  task automatic cyc(input logic [3:0] dout);
    @(negedge i_ref_clk);
    o_sclk = 1'b0;
    o_io   = dout;
    repeat (4) @(negedge i_ref_clk);
    o_sclk = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    for (int k = 0; k < 4; k++) din[k] = i_dev_oe_n[k] ? 1'bx : i_dev_io[k]; // undriven line never matches
  endtask

  // select after the bus has stood idle long enough
  task automatic sel();
    @(negedge i_ref_clk);
    o_cs_n = 1'b0;
  endtask

  // deselect with the clock still high, so no extra rising edge ends the frame
  task automatic desel();
    @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    o_io   = ~o_io;
    repeat (2) @(negedge i_ref_clk);
    o_sclk = 1'b0;
    repeat (8) @(negedge i_ref_clk);
  endtask

  // opcode on io[0], most significant bit first; the other lines held high
  task automatic send(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) cyc({3'b111, op[i]});
  endtask

  // 24-bit address as six nibbles, most significant first
  task automatic addr_q(input logic [23:0] a);
    for (int i = 5; i >= 0; i--) cyc(a[i*4 +: 4]);
  endtask

  task automatic dummy(input int n);
    for (int i = 0; i < n; i++) cyc(4'h0);
  endtask

  // read n bits (io[1]) or n nibbles; released lines toggle so stale values cannot pass
  task automatic rd(input int n, input logic quad, output logic [31:0] q);
    q = '0;
    for (int i = 0; i < n; i++) begin
      cyc(~o_io);
      q = quad ? {q[27:0], din} : {q[30:0], din[1]};
    end
  endtask
endmodule

// file: tb/tb_flash_id_read_and_suspend_cmds.sv
// self-checking bench for the identification reads and the suspend command filter
`timescale 1ns/100ps
`include "flash_id_cfg.svh"

module tb_flash_id_read_and_suspend_cmds;
  localparam logic [7:0] MFR = 8'ha7; // arbitrary value
  localparam logic [7:0] DEV = 8'h2e; // arbitrary value
  localparam logic [7:0] TYP = 8'h61; // arbitrary value
  localparam logic [7:0] CAP = 8'h1b; // arbitrary value

  logic        ref_clk, i_reset, power_good, op_start, op_erase, op_done;
  logic        sclk, cs_n, o_wip, o_prog_susp, o_erase_susp, o_engine_hold, o_cmd_valid;
  logic [3:0]  io_in, o_io, o_io_oe_n;
  logic [7:0]  o_cmd_opcode, fwd_op;
  logic [31:0] q;
  int          n_fail, comparisons, fwd_cnt, n;
  logic [7:0]  ops [34] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
                            8'h02, 8'h12, 8'h32, 8'h34, 8'h06, 8'h05, 8'h35, 8'h15, 8'hc8, 8'hc5,
                            8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc, 8'h3b, 8'h3c, 8'heb, 8'hec,
                            8'h6b, 8'h6c, 8'h66, 8'h99};

  flash_id_suspend #(.MFR_CODE(MFR), .DEV_CODE(DEV), .MEM_TYPE(TYP), .MEM_SIZE(CAP)) i_flash_id_suspend (
    .i_ref_clk(ref_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_io(io_in),
    .i_power_good(power_good), .i_op_start(op_start), .i_op_is_erase(op_erase), .i_op_done(op_done),
    .o_io(o_io), .o_io_oe_n(o_io_oe_n), .o_wip(o_wip), .o_prog_susp(o_prog_susp),
    .o_erase_susp(o_erase_susp), .o_engine_hold(o_engine_hold), .o_cmd_valid(o_cmd_valid),
    .o_cmd_opcode(o_cmd_opcode));

  flash_host_model i_flash_host_model (
    .i_ref_clk(ref_clk), .i_dev_io(o_io), .i_dev_oe_n(o_io_oe_n), .o_sclk(sclk), .o_cs_n(cs_n), .o_io(io_in));

  always #4 ref_clk = ~ref_clk;

  // count opcodes handed on to the rest of the device, looked at mid-cycle where the strobe is settled
  always @(negedge ref_clk) begin
    if (o_cmd_valid === 1'b1) begin
      fwd_cnt++;
      fwd_op = o_cmd_opcode;
    end
  end

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // bounded wait for the busy flag; running out ends the run
  task automatic wait_wip(input logic v, input int lim);
    n = 0;
    while (o_wip !== v) begin
      @(negedge ref_clk);
      n++;
      if (n > lim) begin
        n_fail++;
        $display("wrong value at %0t ns: busy flag wait ran out", $time);
        stop_test();
      end
    end
  endtask

  task automatic pulse(input logic done, input logic er);
    @(negedge ref_clk);
    op_erase = er;
    if (done) op_done = 1'b1;
    else op_start = 1'b1;
    @(negedge ref_clk);
    op_start = 1'b0;
    op_done  = 1'b0;
  endtask

  task automatic one(input logic [7:0] op);
    i_flash_host_model.sel();
    i_flash_host_model.send(op);
    i_flash_host_model.desel();
  endtask

  // opcode while suspended: forwarded or dropped, status left alone when dropped
  task automatic filt(input logic [7:0] op, input logic acc);
    int         c0;
    logic [3:0] f0;
    c0 = fwd_cnt;
    f0 = {o_prog_susp, o_erase_susp, o_wip, o_engine_hold};
    one(op);
    chk(32'(fwd_cnt - c0), {31'h0, acc}, "suspend forward count");
    if (acc) chk({24'h0, fwd_op}, {24'h0, op}, "forwarded opcode");
    else chk({28'h0, o_prog_susp, o_erase_susp, o_wip, o_engine_hold}, {28'h0, f0}, "dropped opcode flags");
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // ident reads only ever meet an awake device: no power-down command is sent
  task automatic t_ident();
    i_flash_host_model.sel();
    i_flash_host_model.send(`OP_IDENT);
    i_flash_host_model.rd(5, 1'b0, q);
    i_flash_host_model.desel();
    chk(q, {27'h0, MFR[7:3]}, "ident cut short");
    chk({28'h0, o_io_oe_n}, 32'hf, "lines released");
    i_flash_host_model.sel();
    i_flash_host_model.send(`OP_IDENT);
    i_flash_host_model.rd(24, 1'b0, q);
    i_flash_host_model.desel();
    chk(q, {8'h0, MFR, TYP, CAP}, "ident bytes");
  endtask

  task automatic t_qid();
    for (int a = 0; a < 2; a++) begin
      i_flash_host_model.sel();
      i_flash_host_model.send(`OP_QIO_ID);
      i_flash_host_model.addr_q(24'(a));
      i_flash_host_model.dummy(6);
      i_flash_host_model.rd(4, 1'b1, q);
      i_flash_host_model.desel();
      chk(q, (a == 1) ? {16'h0, DEV, MFR} : {16'h0, MFR, DEV}, "quad id order");
    end
  endtask

  task automatic t_busy();
    int c0;
    c0 = fwd_cnt;
    pulse(1'b0, 1'b0);
    i_flash_host_model.sel();
    i_flash_host_model.send(`OP_IDENT);
    i_flash_host_model.rd(8, 1'b0, q);
    chk({28'h0, o_io_oe_n}, 32'hf, "ident while busy drives");
    i_flash_host_model.desel();
    chk({31'h0, o_wip}, 32'h1, "busy cycle kept");
    chk(32'(fwd_cnt - c0), 32'h0, "ident forwarded");
    pulse(1'b1, 1'b0);
    wait_wip(1'b0, 10);
  endtask

  task automatic t_susp(input logic er);
    one(`OP_CONTINUE);
    repeat (30) @(negedge ref_clk);
    chk({29'h0, o_prog_susp, o_erase_susp, o_wip}, 32'h0, "resume while idle");
    one(`OP_PAUSE);
    chk({30'h0, o_prog_susp, o_erase_susp}, 32'h0, "pause while idle");
    pulse(1'b0, er);
    one(`OP_PAUSE);
    chk({28'h0, o_prog_susp, o_erase_susp, o_engine_hold, o_wip}, {28'h0, ~er, er, 2'b11}, "pause taken");
    one(`OP_CONTINUE);
    chk({28'h0, o_prog_susp, o_erase_susp, o_engine_hold, o_wip}, {28'h0, ~er, er, 2'b11}, "early resume");
    wait_wip(1'b0, `TSUS_CYC);
    one(`OP_PAUSE);
    chk({28'h0, o_prog_susp, o_erase_susp, o_engine_hold, o_wip}, {28'h0, ~er, er, 2'b10}, "second pause");
    for (int i = 0; i < 34; i++) filt(ops[i], i >= (er ? 10 : 15));
    one(`OP_CONTINUE);
    chk({29'h0, o_prog_susp, o_erase_susp, o_engine_hold}, 32'h0, "resume clears");
    wait_wip(1'b1, `TRES_CYC);
    pulse(1'b1, er);
    wait_wip(1'b0, 10);
  endtask

  task automatic t_power();
    pulse(1'b0, 1'b1);
    one(`OP_PAUSE);
    @(negedge ref_clk);
    power_good = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk({29'h0, o_prog_susp, o_erase_susp, o_wip}, 32'h0, "power loss clears");
    power_good = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask

  // main sequence: reset for four cycles, then each scenario
  initial begin
    ref_clk    = 1'b0;
    i_reset    = 1'b1;
    power_good = 1'b1;
    op_start   = 1'b0;
    op_erase   = 1'b0;
    op_done    = 1'b0;
    repeat (4) @(negedge ref_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_ident();
    t_qid();
    t_busy();
    t_susp(1'b0);
    t_susp(1'b1);
    t_power();
    stop_test();
  end
endmodule
